// *** hw/slf_map.svh ***
`ifndef SLF_MAP_SVH
`define SLF_MAP_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define SLF_ADR_INTEG_GAIN 8'h21
`define SLF_ADR_INTEG_MODE 8'h22
`define SLF_ADR_ACCEL_FF 8'h23
`define SLF_ADR_NOTCH_N1 8'h24
`define SLF_ADR_NOTCH_N2 8'h25
`define SLF_ADR_NOTCH_D1 8'h26
`define SLF_ADR_NOTCH_D2 8'h27
`define SLF_ADR_DPF_GAIN 8'h28
`define SLF_ADR_EXT_FIRST 8'h28
`define SLF_ADR_EXT_LAST 8'h38
`define SLF_ADR_INTEG_LIMIT 8'h3F
`define SLF_ADR_SAT_LIMIT 8'h45
`define SLF_ADR_STATUS 8'h50
`define SLF_ADR_INTEG_VALUE 8'h51
`define SLF_ADR_FILT_POS 8'h52

// ****************************************************************
// reset values
// ****************************************************************
`define SLF_RST_MODE 1'h1
`define SLF_RST_ZERO 24'h000000
`define SLF_RST_SAT_LIMIT 24'h007FFF

// ****************************************************************
// field positions and scaling
// ****************************************************************
`define SLF_STAT_SAT 0
`define SLF_STAT_MODE 1
`define SLF_STAT_LP_ON 2
`define SLF_STAT_EXT 3
`define SLF_COEF_FRAC 22
`define SLF_GAIN_FRAC 24
`define SLF_AFF_SHIFT 8
`define SLF_KI_SHIFT 23
`define SLF_EXT_COUNT 17
`define SLF_WORD_MAX 24'h7FFFFF

`endif

// *** hw/slf_pkg.sv ***
package slf_pkg;

    typedef logic signed [23:0] word_type;
    typedef logic signed [51:0] wide_type;

    typedef struct packed {
        logic mode;
        logic [23:0] ki;
        logic [23:0] aff;
        word_type n1;
        word_type n2;
        word_type d1;
        word_type d2;
        logic [23:0] dpf_gain;
        logic [23:0] int_lim;
        logic [23:0] sat_lim;
    } cfg_type;

    typedef struct packed {
        word_type n1;
        word_type n2;
        word_type d1;
        word_type d2;
    } notch_coef_type;

    typedef struct packed {
        word_type des_pos;
        word_type act_pos;
        word_type des_vel;
        word_type des_acc;
        word_type base_ctl;
    } servo_in_type;

    typedef struct packed {
        word_type ctl;
        word_type filt_pos;
        word_type integ;
        logic sat;
    } servo_out_type;

    function automatic wide_type clamp_sym(input wide_type v, input logic [23:0] lim);
        wide_type l;
        l = $signed({28'h0000000, lim});
        if (v > l) begin
            clamp_sym = l;
        end else if (v < -l) begin
            clamp_sym = -l;
        end else begin
            clamp_sym = v;
        end
    endfunction

endpackage

// *** hw/notch_biquad.sv ***
`timescale 1ns/100ps
`include "slf_map.svh"

module notch_biquad
    import slf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // sample stream
    input wire logic step_i,
    input wire word_type x_i,
    input wire notch_coef_type coef_i,
    output word_type y_o
);

    typedef struct packed {
        word_type x1;
        word_type x2;
        word_type y1;
        word_type y2;
    } notch_state_type;

    notch_state_type st_r;
    notch_state_type st_nxt;
    wide_type acc;
    wide_type y_w;

    // ****************************************************************
    // second-order section, coefficients in 2.22 format
    // ****************************************************************
    always_comb begin
        acc = (52'(x_i) <<< `SLF_COEF_FRAC) + 52'(st_r.x1) * 52'(coef_i.n1)
            + 52'(st_r.x2) * 52'(coef_i.n2) - 52'(st_r.y1) * 52'(coef_i.d1)
            - 52'(st_r.y2) * 52'(coef_i.d2);
        y_w = clamp_sym(acc >>> `SLF_COEF_FRAC, `SLF_WORD_MAX);
        y_o = y_w[23:0];
        st_nxt = st_r;
        if (step_i) begin
            st_nxt.x1 = x_i;
            st_nxt.x2 = st_r.x1;
            st_nxt.y1 = y_o;
            st_nxt.y2 = st_r.y1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_notch_history_shift: assert property (step_i |=> st_r.x1 == $past(x_i) && st_r.x2 == $past(st_r.x1)
        && st_r.y2 == $past(st_r.y1)) else $error("notch history not shifted");
    a_notch_unity_pass: assert property (coef_i == '0 |-> y_o == x_i)
        else $error("notch with zero coefficients is not unity");

endmodule

// *** hw/pos_lowpass.sv ***
`timescale 1ns/100ps
`include "slf_map.svh"

module pos_lowpass
    import slf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // control
    input wire logic step_i,
    input wire logic enable_i,
    input wire logic [23:0] gain_i,
    // sample stream
    input wire word_type x_i,
    output word_type y_o
);

    typedef struct packed {
        word_type prev;
    } lp_state_type;

    lp_state_type st_r;
    lp_state_type st_nxt;
    logic [24:0] comp;
    logic bypass;
    wide_type acc;

    // ****************************************************************
    // first-order smoothing of the net desired position
    // ****************************************************************
    always_comb begin
        comp = 25'h1000000 - {1'b0, gain_i};
        bypass = !enable_i || (gain_i == 24'h000000);
        acc = 52'(st_r.prev) * 52'($signed({1'b0, gain_i}))
            + 52'(x_i) * 52'($signed({1'b0, comp}));
        y_o = bypass ? x_i : acc[47:24];
        st_nxt = st_r;
        if (step_i) begin
            st_nxt.prev = y_o;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_lp_zero_bypass: assert property (step_i && gain_i == 24'h000000 |=> st_r.prev == $past(x_i))
        else $error("zero gain did not bypass the filter");
    a_lp_steady_hold: assert property (step_i && enable_i && x_i == st_r.prev |=> st_r.prev == $past(st_r.prev))
        else $error("filter drifted on a steady input");

endmodule

// *** hw/servo_loop_filter_modifiers.sv ***
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "slf_map.svh"

// Contract
// - With integration mode 1 the integrator takes in error only in servo cycles whose desired velocity is zero.
// - With integration mode 0 the integrator takes in error on every servo cycle in which it is not stopped by saturation.
// - While integration is gated off the integrator contribution holds its last value instead of clearing.
// - While the total output sits at the output saturation limit the integrator stops and holds.
// - The integration mode may be rewritten at any time and acts from the next servo cycle.
// - Acceleration feedforward adds its unsigned 23-bit gain times desired acceleration, divided by 256, to the output.
// - The notch is one plus two numerator taps over one plus two denominator taps on one and two sample delays.
// - Each notch coefficient is a 24-bit signed word with one integer bit and 22 fraction bits.
// - A first-order low-pass may smooth the net desired position before the loop uses it.
// - A desired-position filter gain of zero bypasses the low-pass and any larger gain enables it.
// - The filter gain is a fraction below one equal to time constant over update period plus time constant.
// - With the extended servo option and lookahead both present the low-pass is not provided.
// - Indices 40 to 56 hold extended algorithm gains only when the extended servo option is installed.
// - The integrator sums error times integral gain and with an integration limit of zero contributes nothing.
module servo_loop_filter_modifiers
    import slf_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter bit EXT_SERVO_OPT = 1'b0,
    parameter bit LOOKAHEAD_OPT = 1'b1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [23:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [23:0] reg_rdata_o,
    // servo stream
    input wire logic servo_tick_i,
    input wire servo_in_type servo_in_i,
    output logic servo_valid_o,
    output servo_out_type servo_out_o
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (DATA_W != 24) begin : g_bad_width
        $error("servo filter supports only 24-bit data");
    end

    typedef struct packed {
        cfg_type cfg;
        logic [`SLF_EXT_COUNT-1:0][23:0] ext;
        word_type integ;
        logic sat;
        logic valid;
        servo_out_type out;
        logic [23:0] rdata;
    } state_type;

    localparam bit LP_AVAIL = LOOKAHEAD_OPT && !EXT_SERVO_OPT;

    state_type st_r;
    state_type st_nxt;
    word_type lp_pos;
    word_type notch_x;
    word_type notch_y;
    notch_coef_type coefs;
    wide_type err;
    wide_type ki_term;
    wide_type aff_term;
    wide_type integ_w;
    wide_type sum_w;
    wide_type ctl_w;
    wide_type lim_w;
    logic acc_en;
    logic sat_now;
    logic ext_hit;
    logic [7:0] ext_off;
    logic [4:0] ext_idx;

    // ****************************************************************
    // desired position smoothing
    // ****************************************************************
    pos_lowpass u_pos_lowpass (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .step_i(servo_tick_i),
        .enable_i(LP_AVAIL),
        .gain_i(st_r.cfg.dpf_gain),
        .x_i(servo_in_i.des_pos),
        .y_o(lp_pos)
    );

    // ****************************************************************
    // output notch
    // ****************************************************************
    assign coefs = '{n1: st_r.cfg.n1, n2: st_r.cfg.n2, d1: st_r.cfg.d1, d2: st_r.cfg.d2};

    notch_biquad u_notch_biquad (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .step_i(servo_tick_i),
        .x_i(notch_x),
        .coef_i(coefs),
        .y_o(notch_y)
    );

    // ****************************************************************
    // servo datapath
    // ****************************************************************
    always_comb begin
        err = 52'(lp_pos) - 52'(servo_in_i.act_pos);
        ki_term = (err * 52'($signed({1'b0, st_r.cfg.ki}))) >>> `SLF_KI_SHIFT;
        acc_en = (!st_r.cfg.mode || servo_in_i.des_vel == 24'h000000) && !st_r.sat;
        integ_w = acc_en ? 52'(st_r.integ) + ki_term : 52'(st_r.integ);
        integ_w = clamp_sym(clamp_sym(integ_w, st_r.cfg.int_lim), `SLF_WORD_MAX);
        aff_term = (52'($signed({1'b0, st_r.cfg.aff})) * 52'(servo_in_i.des_acc)) >>> `SLF_AFF_SHIFT;
        sum_w = 52'(servo_in_i.base_ctl) + integ_w + aff_term;
        sum_w = clamp_sym(sum_w, `SLF_WORD_MAX);
        notch_x = sum_w[23:0];
        lim_w = $signed({28'h0000000, st_r.cfg.sat_lim});
        ctl_w = clamp_sym(52'(notch_y), st_r.cfg.sat_lim);
        sat_now = (52'(notch_y) >= lim_w) || (52'(notch_y) <= -lim_w);
    end

    // ****************************************************************
    // register decode
    // ****************************************************************
    always_comb begin
        ext_off = reg_addr_i - `SLF_ADR_EXT_FIRST;
        ext_idx = ext_off[4:0];
        ext_hit = EXT_SERVO_OPT && reg_addr_i >= `SLF_ADR_EXT_FIRST && reg_addr_i <= `SLF_ADR_EXT_LAST;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.rdata = 24'h000000;
        if (reg_wr_i) begin
            if (ext_hit) begin
                st_nxt.ext[ext_idx] = reg_wdata_i;
            end else begin
                unique case (reg_addr_i)
                    `SLF_ADR_INTEG_GAIN: st_nxt.cfg.ki = {1'b0, reg_wdata_i[22:0]};
                    `SLF_ADR_INTEG_MODE: st_nxt.cfg.mode = reg_wdata_i[0];
                    `SLF_ADR_ACCEL_FF: st_nxt.cfg.aff = {1'b0, reg_wdata_i[22:0]};
                    `SLF_ADR_NOTCH_N1: st_nxt.cfg.n1 = reg_wdata_i;
                    `SLF_ADR_NOTCH_N2: st_nxt.cfg.n2 = reg_wdata_i;
                    `SLF_ADR_NOTCH_D1: st_nxt.cfg.d1 = reg_wdata_i;
                    `SLF_ADR_NOTCH_D2: st_nxt.cfg.d2 = reg_wdata_i;
                    `SLF_ADR_DPF_GAIN: st_nxt.cfg.dpf_gain = LP_AVAIL ? reg_wdata_i : 24'h000000;
                    `SLF_ADR_INTEG_LIMIT: st_nxt.cfg.int_lim = {1'b0, reg_wdata_i[22:0]};
                    `SLF_ADR_SAT_LIMIT: st_nxt.cfg.sat_lim = {1'b0, reg_wdata_i[22:0]};
                    default: begin
                    end
                endcase
            end
        end
        if (reg_rd_i) begin
            if (ext_hit) begin
                st_nxt.rdata = st_r.ext[ext_idx];
            end else begin
                unique case (reg_addr_i)
                    `SLF_ADR_INTEG_GAIN: st_nxt.rdata = st_r.cfg.ki;
                    `SLF_ADR_INTEG_MODE: st_nxt.rdata = {23'h0, st_r.cfg.mode};
                    `SLF_ADR_ACCEL_FF: st_nxt.rdata = st_r.cfg.aff;
                    `SLF_ADR_NOTCH_N1: st_nxt.rdata = st_r.cfg.n1;
                    `SLF_ADR_NOTCH_N2: st_nxt.rdata = st_r.cfg.n2;
                    `SLF_ADR_NOTCH_D1: st_nxt.rdata = st_r.cfg.d1;
                    `SLF_ADR_NOTCH_D2: st_nxt.rdata = st_r.cfg.d2;
                    `SLF_ADR_DPF_GAIN: st_nxt.rdata = st_r.cfg.dpf_gain;
                    `SLF_ADR_INTEG_LIMIT: st_nxt.rdata = st_r.cfg.int_lim;
                    `SLF_ADR_SAT_LIMIT: st_nxt.rdata = st_r.cfg.sat_lim;
                    `SLF_ADR_STATUS: begin
                        st_nxt.rdata[`SLF_STAT_SAT] = st_r.sat;
                        st_nxt.rdata[`SLF_STAT_MODE] = st_r.cfg.mode;
                        st_nxt.rdata[`SLF_STAT_LP_ON] = LP_AVAIL && st_r.cfg.dpf_gain != 24'h000000;
                        st_nxt.rdata[`SLF_STAT_EXT] = EXT_SERVO_OPT;
                    end
                    `SLF_ADR_INTEG_VALUE: st_nxt.rdata = st_r.integ;
                    `SLF_ADR_FILT_POS: st_nxt.rdata = st_r.out.filt_pos;
                    default: begin
                    end
                endcase
            end
        end
        if (servo_tick_i) begin
            st_nxt.integ = integ_w[23:0];
            st_nxt.sat = sat_now;
            st_nxt.valid = 1'b1;
            st_nxt.out.ctl = ctl_w[23:0];
            st_nxt.out.filt_pos = lp_pos;
            st_nxt.out.integ = integ_w[23:0];
            st_nxt.out.sat = sat_now;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
            st_r.cfg.mode <= `SLF_RST_MODE;
            st_r.cfg.dpf_gain <= `SLF_RST_ZERO;
            st_r.cfg.int_lim <= `SLF_RST_ZERO;
            st_r.cfg.sat_lim <= `SLF_RST_SAT_LIMIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata_o = st_r.rdata;
    assign servo_valid_o = st_r.valid;
    assign servo_out_o = st_r.out;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    wide_type integ_abs_room;
    logic integ_in_lim;
    always_comb begin
        integ_abs_room = $signed({28'h0000000, st_r.cfg.int_lim});
        integ_in_lim = 52'(st_r.integ) <= integ_abs_room && 52'(st_r.integ) >= -integ_abs_room;
    end

    a_mode_move_hold: assert property (servo_tick_i && st_r.cfg.mode && servo_in_i.des_vel != 24'h000000
        && integ_in_lim |=> st_r.integ == $past(st_r.integ))
        else $error("integrator moved during a commanded move");
    a_mode_zero_accum: assert property (servo_tick_i && !st_r.cfg.mode && !st_r.sat && st_r.integ == 24'h000000
        && ki_term > 0 && st_r.cfg.int_lim != 24'h000000 |=> st_r.integ > 0)
        else $error("integrator idle in mode zero");
    a_integ_hold_kept: assert property (servo_tick_i && !acc_en && st_r.integ != 24'h000000 && integ_in_lim
        |=> st_r.integ != 24'h000000) else $error("held integrator was cleared");
    a_sat_integ_freeze: assert property (servo_tick_i && st_r.sat && integ_in_lim
        |=> st_r.integ == $past(st_r.integ)) else $error("integrator ran while saturated");
    a_mode_write_next: assert property (reg_wr_i && reg_addr_i == `SLF_ADR_INTEG_MODE
        |=> st_r.cfg.mode == $past(reg_wdata_i[0])) else $error("mode write not applied");
    a_zero_limit_zero: assert property (servo_tick_i && st_r.cfg.int_lim == 24'h000000
        |=> st_r.integ == 24'h000000 && servo_out_o.integ == 24'h000000)
        else $error("integrator nonzero with zero limit");
    a_out_within_limit: assert property (servo_valid_o |-> 52'(servo_out_o.ctl) <= lim_w
        && 52'(servo_out_o.ctl) >= -lim_w) else $error("output beyond saturation limit");
    a_lp_absent_pass: assert property (!LP_AVAIL |-> lp_pos == servo_in_i.des_pos)
        else $error("low-pass active without its option");
    a_ext_space_idle: assert property (!EXT_SERVO_OPT && reg_rd_i && reg_addr_i > `SLF_ADR_EXT_FIRST
        && reg_addr_i <= `SLF_ADR_EXT_LAST |=> reg_rdata_o == 24'h000000)
        else $error("extended gain space answered without option");
    a_aff_zero_acc: assert property (servo_tick_i && servo_in_i.des_acc == 24'h000000 |-> aff_term == 0)
        else $error("feedforward term without acceleration");

    c_move_hold: cover property (servo_tick_i && st_r.cfg.mode && servo_in_i.des_vel != 24'h000000);
    c_saturated: cover property (servo_tick_i && sat_now);
    c_lp_enabled: cover property (servo_tick_i && st_r.cfg.dpf_gain != 24'h000000);

endmodule

// *** sim/servo_loop_filter_modifiers_tb.sv ***
`timescale 1ns/100ps
`include "slf_map.svh"

module servo_loop_filter_modifiers_tb
    import slf_pkg::*;
;
    logic clk;
    logic arst_n;
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
    logic [23:0] rdata;
    logic tick;
    servo_in_type sin;
    logic valid;
    servo_out_type sout;
    int fails;
    int check_count;

    servo_loop_filter_modifiers u_dut (
        .clk_sys_i(clk),
        .arst_n_i(arst_n),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .servo_tick_i(tick),
        .servo_in_i(sin),
        .servo_valid_o(valid),
        .servo_out_o(sout)
    );

    // ****************************************************************
    // bus and stream tasks
    // ****************************************************************
    task summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [23:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task step(input word_type dp, input word_type ap, input word_type dv, input word_type da, input word_type bc);
        int n;
        @(posedge clk);
        tick <= 1'b1;
        sin <= '{dp, ap, dv, da, bc};
        @(posedge clk);
        tick <= 1'b0;
        #1;
        n = 0;
        while (valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4) begin
            fails++;
            summarize();
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task test_reset();
        rd_chk(`SLF_ADR_INTEG_MODE, 24'h000001);
        rd_chk(`SLF_ADR_SAT_LIMIT, 24'h007FFF);
        rd_chk(`SLF_ADR_ACCEL_FF, 24'h000000);
        wr_reg(8'h10, 24'h123456);
        rd_chk(8'h10, 24'h000000);
        $display("test reset done");
    endtask

    task test_notch();
        wr_reg(`SLF_ADR_NOTCH_N1, 24'h400000);
        wr_reg(`SLF_ADR_NOTCH_D1, 24'h200000);
        wr_reg(`SLF_ADR_NOTCH_N2, 24'h200000);
        wr_reg(`SLF_ADR_NOTCH_D2, 24'hF00000);
        rd_chk(`SLF_ADR_NOTCH_D1, 24'h200000);
        rd_chk(`SLF_ADR_NOTCH_D2, 24'hF00000);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h000064);
        chk(sout.ctl, 24'h000064);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.ctl, 24'h000032);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.ctl, 24'h000032);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.ctl, 24'hFFFFF3);
        wr_reg(`SLF_ADR_NOTCH_N1, 24'h0);
        wr_reg(`SLF_ADR_NOTCH_D1, 24'h0);
        wr_reg(`SLF_ADR_NOTCH_N2, 24'h0);
        wr_reg(`SLF_ADR_NOTCH_D2, 24'h0);
        $display("test notch done");
    endtask

    task test_accel();
        wr_reg(`SLF_ADR_ACCEL_FF, 24'h000100);
        step(24'h0, 24'h0, 24'h0, 24'h000005, 24'h0);
        chk(sout.ctl, 24'h000005);
        step(24'h0, 24'h0, 24'h0, 24'hFFFD00, 24'h0);
        chk(sout.ctl, 24'hFFFD00);
        wr_reg(`SLF_ADR_ACCEL_FF, 24'h0);
        $display("test accel done");
    endtask

    task test_lowpass();
        step(24'h0003E8, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.filt_pos, 24'h0003E8);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        wr_reg(`SLF_ADR_DPF_GAIN, 24'h800000);
        rd_chk(`SLF_ADR_DPF_GAIN, 24'h800000);
        rd_chk(`SLF_ADR_STATUS, 24'h000006);
        step(24'h0003E8, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.filt_pos, 24'h0001F4);
        step(24'h0003E8, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.filt_pos, 24'h0002EE);
        rd_chk(`SLF_ADR_FILT_POS, 24'h0002EE);
        wr_reg(`SLF_ADR_DPF_GAIN, 24'h0);
        step(24'h0, 24'h0, 24'h0, 24'h0, 24'h0);
        chk(sout.filt_pos, 24'h000000);
        rd_chk(`SLF_ADR_EXT_LAST, 24'h000000);
        $display("test lowpass done");
    endtask

    task test_integ();
        wr_reg(`SLF_ADR_INTEG_GAIN, 24'h400000);
        wr_reg(`SLF_ADR_INTEG_LIMIT, 24'h001000);
        step(24'h0, 24'hFFFFEC, 24'h000005, 24'h0, 24'h0);
        chk(sout.integ, 24'h000000);
        step(24'h0, 24'hFFFFEC, 24'h0, 24'h0, 24'h0);
        chk(sout.integ, 24'h00000A);
        step(24'h0, 24'hFFFFEC, 24'h000005, 24'h0, 24'h0);
        chk(sout.integ, 24'h00000A);
        chk(sout.ctl, 24'h00000A);
        wr_reg(`SLF_ADR_INTEG_MODE, 24'h0);
        step(24'h0, 24'hFFFFEC, 24'h000005, 24'h0, 24'h0);
        chk(sout.integ, 24'h000014);
        rd_chk(`SLF_ADR_INTEG_VALUE, 24'h000014);
        wr_reg(`SLF_ADR_INTEG_LIMIT, 24'h0);
        step(24'h0, 24'hFFFFEC, 24'h000005, 24'h0, 24'h0);
        chk(sout.integ, 24'h000000);
        $display("test integ done");
    endtask

    task test_sat();
        wr_reg(`SLF_ADR_INTEG_LIMIT, 24'h001000);
        wr_reg(`SLF_ADR_SAT_LIMIT, 24'h000008);
        step(24'h0, 24'hFFFFEC, 24'h0, 24'h0, 24'h000064);
        chk(sout.integ, 24'h00000A);
        chk(sout.ctl, 24'h000008);
        chk({23'h0, sout.sat}, 24'h000001);
        step(24'h0, 24'hFFFFEC, 24'h0, 24'h0, 24'h000064);
        chk(sout.integ, 24'h00000A);
        wr_reg(`SLF_ADR_SAT_LIMIT, 24'h007FFF);
        $display("test sat done");
    endtask

    // ****************************************************************
    // clock, reset and sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        fails = 0;
        check_count = 0;
        arst_n = 1'b0;
        addr = 8'h00;
        wdata = 24'h000000;
        wr = 1'b0;
        rd = 1'b0;
        tick = 1'b0;
        sin = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        test_reset();
        test_notch();
        test_accel();
        test_lowpass();
        test_integ();
        test_sat();
        summarize();
    end
endmodule
